// *** inc/power_save_pkg.sv ***
// Package: register map, field layout, reset values and modes of the power-save clock control block
package power_save_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned 32-bit word each)
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 12;
	localparam int          GATE_REGS     = 8;
	localparam int          REG_W         = 16;
	localparam logic [11:0] GATE_BASE     = 12'h000;
	localparam logic [11:0] OWN_EN_BASE   = 12'h020;
	localparam logic [11:0] IDLE_BASE     = 12'h040;
	localparam logic [11:0] CLOCK_DIVIDER_REG_OFS    = 12'h060;
	localparam logic [11:0] RESET_CONTROL_REG_OFS      = 12'h064;
	localparam logic [11:0] STATUS_OFS    = 12'h068;
	localparam logic [11:0] BANK_MASK     = 12'hFE0;

	// ----------------------------------------------------------------
	// Implemented bits of the eight module gate registers
	// ----------------------------------------------------------------
	localparam logic [7:0][15:0] GATE_MASK = {
		16'h000C, 16'h0030, 16'h0001, 16'h000F,
		16'h000E, 16'h0782, 16'h0707, 16'h38F9};
	// Capture, compare and calendar have no own enable
	localparam logic [7:0][15:0] OWN_MASK = {
		16'h000C, 16'h0030, 16'h0001, 16'h000F,
		16'h000E, 16'h0582, 16'h0000, 16'h38F9};
	localparam logic [15:0] GATE_RESET    = 16'h0000;
	localparam logic [15:0] OWN_RESET     = 16'h0000;
	localparam logic [15:0] IDLE_RESET    = 16'h0000;

	// ----------------------------------------------------------------
	// Clock divider and reset control fields
	// ----------------------------------------------------------------
	localparam int          IRQ_FULL_BIT  = 15;
	localparam int          RATIO_LSB     = 12;
	localparam int          RATIO_W       = 3;
	localparam int          DOZE_EN_BIT   = 11;
	localparam logic [15:0] CLOCK_DIVIDER_REG_RESET  = 16'h0000;
	localparam int          RETENTION_SLEEP_SELECT_BIT     = 12;
	localparam int          VREG_BIT      = 8;
	localparam logic [15:0] RESET_CONTROL_REG_RESET    = 16'h0000;

	// Status word layout
	localparam int          ST_DOZE_BIT   = 0;
	localparam int          ST_RATIO_LSB  = 1;
	localparam int          ST_SLEEP_LSB  = 4;

	// Divider period minus one for ratio codes 1 to 7; code 0 is forced to 1:1
	localparam int          DIV_W         = 8;
	localparam logic [7:0][7:0] RATIO_RELOAD = {
		8'hFF, 8'h7F, 8'h3F, 8'h1F, 8'h0F, 8'h07, 8'h03, 8'h01};
	localparam logic [7:0]  RATIO_ONE     = 8'h00;

	// Sleep variant, coded as {retention, regulator standby}
	typedef enum logic [1:0] {
		SLEEP_FAST_WAKE      = 2'b00,
		SLEEP_NORMAL         = 2'b01,
		SLEEP_RETENTION      = 2'b11,
		SLEEP_FAST_RETENTION = 2'b10
	} sleep_variant_t;

	typedef enum logic {
		FULL_SPEED = 1'b0,
		DOZING     = 1'b1
	} doze_state_t;

endpackage

// *** hw/power_save_clock_gating.sv ***
// Power-save clock control: sleep variant decode, doze divider, module clock gating, APB registers
`timescale 1ns/10ps

module power_save_clock_gating #(
	parameter int N_GATE = power_save_pkg::GATE_REGS    // Number of module gate registers
) (
	input  wire logic                         pclk,           // System clock
	input  wire logic                         presetn,        // Async reset, active low
	input  wire logic                         psel,           // APB select
	input  wire logic                         penable,        // APB access phase
	input  wire logic                         pwrite,         // APB direction, high is write
	input  wire logic [power_save_pkg::ADDR_W-1:0] paddr,     // APB byte address
	input  wire logic [31:0]                  pwdata,         // APB write data
	input  wire logic [3:0]                   pstrb,          // APB byte strobes
	output logic      [31:0]                  prdata,         // APB read data
	output logic                              pready,         // APB ready
	output logic                              pslverr,        // APB error, unmapped address
	input  wire logic                         irq_event,      // Interrupt event from controller
	input  wire logic                         cpu_idle,       // CPU is in Idle
	output logic                              cpu_clk_en,     // CPU clock enable tick
	output logic                              doze_active,    // Doze mode in use; CPU clock divided except at ratio code 0
	output power_save_pkg::sleep_variant_t    sleep_variant,  // Selected sleep flavour
	output logic [N_GATE*16-1:0]              periph_clk_en,  // Per-module clock enable
	output logic [N_GATE*16-1:0]              periph_regs_en, // Per-module register access
	output logic [N_GATE*16-1:0]              periph_run      // Per-module function enable
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [N_GATE-1:0][15:0]  gate;        // Module gate registers
		logic [N_GATE-1:0][15:0]  own_en;      // Module own enables
		logic [N_GATE-1:0][15:0]  idle_stop;   // Module stop-in-idle bits
		logic                     irq_full;    // Return to full speed on irq
		logic [2:0]               ratio;       // Requested ratio code
		logic                     doze_req;    // Requested doze
		logic                     retention_sleep_select;       // Retention sleep select
		logic                     vreg;        // Regulator standby select
		power_save_pkg::doze_state_t mode;     // Applied doze mode
		logic [2:0]               act_ratio;   // Applied ratio code
		logic [7:0]               div_cnt;     // Divider down counter
		logic [N_GATE*16-1:0]     clk_en;      // Registered clock enables
		logic [N_GATE*16-1:0]     run;         // Registered function enables
		logic [31:0]              rdata;       // Captured read word
		logic                     err;         // Captured decode error
	} state_t;

	state_t st;
	state_t next_st;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic       setup_ph;
	logic       access_wr;
	logic [2:0] word_idx;
	logic       hit_gate;
	logic       hit_own;
	logic       hit_idle;
	logic       hit_clock_divider_reg;
	logic       hit_reset_control_reg;
	logic       hit_status;
	logic       hit_any;
	logic       lo_strb;

	// Bank hits compare the upper address bits, word index picks the entry
	assign setup_ph   = psel & ~penable;
	assign access_wr  = psel & penable & pwrite & ~st.err;
	assign word_idx   = paddr[4:2];
	assign hit_gate   = ((paddr & power_save_pkg::BANK_MASK) == power_save_pkg::GATE_BASE) && (paddr[1:0] == 2'b00);
	assign hit_own    = ((paddr & power_save_pkg::BANK_MASK) == power_save_pkg::OWN_EN_BASE) && (paddr[1:0] == 2'b00);
	assign hit_idle   = ((paddr & power_save_pkg::BANK_MASK) == power_save_pkg::IDLE_BASE) && (paddr[1:0] == 2'b00);
	assign hit_clock_divider_reg = (paddr == power_save_pkg::CLOCK_DIVIDER_REG_OFS);
	assign hit_reset_control_reg   = (paddr == power_save_pkg::RESET_CONTROL_REG_OFS);
	assign hit_status = (paddr == power_save_pkg::STATUS_OFS);
	assign hit_any    = hit_gate | hit_own | hit_idle | hit_clock_divider_reg | hit_reset_control_reg | hit_status;
	// Registers are 16 bits wide, so only the two low lanes matter
	assign lo_strb    = pstrb[0] | pstrb[1];

	// ----------------------------------------------------------------
	// Read word mux
	// ----------------------------------------------------------------
	logic [31:0] read_word;

	// Unimplemented bits are zero because stored values are masked
	always_comb begin
		read_word = 32'h0000_0000;
		if (hit_gate) begin
			read_word = {16'h0000, st.gate[word_idx]};
		end else if (hit_own) begin
			read_word = {16'h0000, st.own_en[word_idx]};
		end else if (hit_idle) begin
			read_word = {16'h0000, st.idle_stop[word_idx]};
		end else if (hit_clock_divider_reg) begin
			read_word[power_save_pkg::IRQ_FULL_BIT] = st.irq_full;
			read_word[power_save_pkg::RATIO_LSB +: power_save_pkg::RATIO_W] = st.ratio;
			read_word[power_save_pkg::DOZE_EN_BIT] = st.doze_req;
		end else if (hit_reset_control_reg) begin
			read_word[power_save_pkg::RETENTION_SLEEP_SELECT_BIT] = st.retention_sleep_select;
			read_word[power_save_pkg::VREG_BIT] = st.vreg;
		end else if (hit_status) begin
			read_word[power_save_pkg::ST_DOZE_BIT] = (st.mode == power_save_pkg::DOZING);
			read_word[power_save_pkg::ST_RATIO_LSB +: 3] = st.act_ratio;
			read_word[power_save_pkg::ST_SLEEP_LSB +: 2] = {st.retention_sleep_select, st.vreg};
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic boundary;
	logic [N_GATE*16-1:0] mask_flat;
	logic [N_GATE*16-1:0] no_own_flat;

	// Divider period ends when the down counter reaches zero
	assign boundary = (st.div_cnt == power_save_pkg::RATIO_ONE);

	always_comb begin
		next_st = st;

		// Read data and decode error caught in setup so they come from flops
		if (setup_ph) begin
			next_st.rdata = read_word;
			next_st.err   = ~hit_any;
		end

		// Register writes take effect at the access edge, masked to implemented bits
		if (access_wr && lo_strb) begin
			if (hit_gate) begin
				next_st.gate[word_idx] = pwdata[15:0] & power_save_pkg::GATE_MASK[word_idx];
			end else if (hit_own) begin
				next_st.own_en[word_idx] = pwdata[15:0] & power_save_pkg::OWN_MASK[word_idx];
			end else if (hit_idle) begin
				next_st.idle_stop[word_idx] = pwdata[15:0] & power_save_pkg::GATE_MASK[word_idx];
			end else if (hit_reset_control_reg) begin
				next_st.retention_sleep_select = pwdata[power_save_pkg::RETENTION_SLEEP_SELECT_BIT];
				next_st.vreg  = pwdata[power_save_pkg::VREG_BIT];
			end
		end

		// Interrupt leaves doze only with the return bit set; a write in the same cycle wins
		if (st.irq_full && irq_event) begin
			next_st.doze_req = 1'b0;
		end
		if (access_wr && lo_strb && hit_clock_divider_reg) begin
			next_st.irq_full = pwdata[power_save_pkg::IRQ_FULL_BIT];
			next_st.ratio    = pwdata[power_save_pkg::RATIO_LSB +: power_save_pkg::RATIO_W];
			next_st.doze_req = pwdata[power_save_pkg::DOZE_EN_BIT];
		end

		// Doze mode and ratio applied only at a period boundary, never mid-cycle
		if (boundary) begin
			next_st.act_ratio = next_st.ratio;
			if (next_st.doze_req) begin
				next_st.mode    = power_save_pkg::DOZING;
				next_st.div_cnt = power_save_pkg::RATIO_RELOAD[next_st.ratio];
			end else begin
				next_st.mode    = power_save_pkg::FULL_SPEED;
				next_st.div_cnt = power_save_pkg::RATIO_ONE;
			end
			if (next_st.ratio == 3'b000) begin
				next_st.div_cnt = power_save_pkg::RATIO_ONE;
			end
		end else begin
			next_st.div_cnt = st.div_cnt - 8'h01;
		end

		// Enables registered here so they only move at the rising edge
		next_st.clk_en = mask_flat & ~next_st.gate;
		// Packed banks line up bit for bit with the flat enables; no loop through outside nets
		next_st.run    = next_st.clk_en & (next_st.own_en | no_own_flat)
			& ~(cpu_idle ? next_st.idle_stop : {N_GATE*16{1'b0}});
	end

	// ----------------------------------------------------------------
	// Per-register flattening of the implemented-bit and own-enable masks
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_GATE; gi++) begin : g_bank
			assign mask_flat[gi*16 +: 16]   = power_save_pkg::GATE_MASK[gi];
			// Modules without an own enable always count as enabled
			assign no_own_flat[gi*16 +: 16] = power_save_pkg::GATE_MASK[gi] & ~power_save_pkg::OWN_MASK[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Every reset clears all gate bits and the clock enables, so the clock enables come back up at the first edge after release; the CPU returns to 1:1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.gate      <= {N_GATE{power_save_pkg::GATE_RESET}};
			st.own_en    <= {N_GATE{power_save_pkg::OWN_RESET}};
			st.idle_stop <= {N_GATE{power_save_pkg::IDLE_RESET}};
			st.irq_full  <= power_save_pkg::CLOCK_DIVIDER_REG_RESET[power_save_pkg::IRQ_FULL_BIT];
			st.ratio     <= power_save_pkg::CLOCK_DIVIDER_REG_RESET[power_save_pkg::RATIO_LSB +: power_save_pkg::RATIO_W];
			st.doze_req  <= power_save_pkg::CLOCK_DIVIDER_REG_RESET[power_save_pkg::DOZE_EN_BIT];
			st.retention_sleep_select     <= power_save_pkg::RESET_CONTROL_REG_RESET[power_save_pkg::RETENTION_SLEEP_SELECT_BIT];
			st.vreg      <= power_save_pkg::RESET_CONTROL_REG_RESET[power_save_pkg::VREG_BIT];
			st.mode      <= power_save_pkg::FULL_SPEED;
			st.act_ratio <= 3'b000;
			st.div_cnt   <= power_save_pkg::RATIO_ONE;
			st.clk_en    <= {N_GATE*16{1'b0}};
			st.run       <= {N_GATE*16{1'b0}};
			st.rdata     <= 32'h0000_0000;
			st.err       <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Zero wait states; the read word is already in a flop at access
	assign pready         = 1'b1;
	assign pslverr        = psel & penable & st.err;
	assign prdata         = st.rdata;

	// CPU ticks once per divider period, phase locked to pclk
	assign cpu_clk_en     = (st.mode == power_save_pkg::FULL_SPEED) | boundary;
	assign doze_active    = (st.mode == power_save_pkg::DOZING);
	assign sleep_variant  = power_save_pkg::sleep_variant_t'({st.retention_sleep_select, st.vreg});

	// A gated module loses both its clock and its register port
	assign periph_clk_en  = st.clk_en;
	assign periph_regs_en = st.clk_en;
	assign periph_run     = st.run;

endmodule // power_save_clock_gating

// *** sim/power_save_clock_gating_properties.sv ***
// Checker: port timing of the power-save clock block
`timescale 1ns/10ps
module power_save_clock_gating_properties #(
	parameter int N_GATE = 8  // Gate registers
) (
	input wire logic                              pclk,           // Clock
	input wire logic                              presetn,        // Reset
	input wire logic                              psel,           // Select
	input wire logic                              penable,        // Access
	input wire logic                              pwrite,         // Write
	input wire logic [11:0]                       paddr,          // Address
	input wire logic                              pready,         // Ready
	input wire logic                              pslverr,        // Error
	input wire logic                              cpu_clk_en,     // CPU tick
	input wire logic                              doze_active,    // Doze
	input wire power_save_pkg::sleep_variant_t    sleep_variant,  // Sleep kind
	input wire logic [N_GATE*16-1:0]              periph_clk_en,  // Clocks
	input wire logic [N_GATE*16-1:0]              periph_regs_en, // Regs
	input wire logic [N_GATE*16-1:0]              periph_run      // Run
);
	// Implemented gate bits, cast so a smaller N_GATE still elaborates
	localparam logic [N_GATE*16-1:0] IMPL = (N_GATE*16)'(power_save_pkg::GATE_MASK);
	wire logic wr_acc = psel && penable && pwrite;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_always_a: assert property (pready) else $error("ready low");
	err_unmapped_a: assert property (psel && penable && paddr >= 12'h06C |-> pslverr) else $error("no error");
	err_access_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
	full_tick_a: assert property (!doze_active |-> cpu_clk_en) else $error("tick lost");
	doze_tick_a: assert property (doze_active |-> ##[0:255] cpu_clk_en) else $error("tick late");
	mode_edge_a: assert property ($changed(doze_active) |-> $past(cpu_clk_en)) else $error("mid period");
	doze_cause_a: assert property ($rose(doze_active) |-> $past(wr_acc, 1) || $past(wr_acc, 2)) else $error("doze");
	unimpl_zero_a: assert property ((periph_clk_en & ~IMPL) == '0) else $error("unimpl bit");
	regs_follow_a: assert property (periph_regs_en == periph_clk_en) else $error("regs");
	gate_cause_a: assert property ($changed(periph_clk_en) |-> $past(wr_acc) || !$past(presetn, 2)) else $error("gate");
	sleep_cause_a: assert property ($changed(sleep_variant) |-> $past(wr_acc, 1) || $past(wr_acc, 2)) else $error("slp");
	run_clock_a: assert property ((periph_run & ~periph_clk_en & ~$past(periph_clk_en)) == '0) else $error("run");

	// Main scenarios reached
	cover property (doze_active && !cpu_clk_en);
	cover property (pslverr);
	cover property ($fell(doze_active));
endmodule // power_save_clock_gating_properties

// *** sim/power_save_clock_gating_bench.sv ***
// Testbench: register table, doze, sleep decode and gating checks
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module power_save_clock_gating_bench;
	typedef struct {logic [11:0] addr; logic [15:0] exp;} row_t;
	logic pclk, presetn, psel, penable, pwrite, irq_event, cpu_idle, pready, pslverr, cpu_clk_en, doze_active, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [127:0] periph_clk_en, periph_regs_en, periph_run, all_impl;
	power_save_pkg::sleep_variant_t sleep_variant;
	logic [15:0] impl [8] = '{16'h38F9, 16'h0707, 16'h0782, 16'h000E, 16'h000F, 16'h0001, 16'h0030, 16'h000C};
	int per [8] = '{1, 4, 8, 16, 32, 64, 128, 256};
	int failures = 0;
	int checks_done = 0;
	int n;
	row_t rows [11];

	power_save_clock_gating power_save_clock_gating_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_event(irq_event), .cpu_idle(cpu_idle), .cpu_clk_en(cpu_clk_en),
		.doze_active(doze_active), .sleep_variant(sleep_variant), .periph_clk_en(periph_clk_en),
		.periph_regs_en(periph_regs_en), .periph_run(periph_run));

	// 10 MHz clock
	always #50 pclk = ~pclk;

	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// One APB transfer; request held until pready seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// Cycles between CPU ticks, bounded so a stuck tick cannot hang
	task automatic gap;
		n = 0;
		do begin @(posedge pclk); n++; end while (cpu_clk_en !== 1'b1 && n < 300);
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		tick(12);
		presetn <= 1'b1;
		tick(2);
		`CHK(periph_clk_en, all_impl)
		`CHK(periph_run[47:16], 32'h0200_0707)
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Watchdog well past the expected run of about 1350 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		test_done;
	end

	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		pstrb = 4'hF; irq_event = 1'b0; cpu_idle = 1'b0;
		for (int r = 0; r < 8; r++) begin
			all_impl[16*r+:16] = impl[r];
			rows[r] = '{12'(4*r), impl[r]};
		end
		rows[8] = '{12'h024, 16'h0000};
		rows[9] = '{12'h028, 16'h0582};
		rows[10] = '{12'h068, 16'h0000};
		do_reset;
		// Table: reset value, written ones, gating effect, clear restores
		foreach (rows[i]) begin
			apb(1'b0, rows[i].addr, 32'h0);
			`CHK(rd, 32'h0)
			apb(1'b1, rows[i].addr, 32'hFFFF_FFFF);
			apb(1'b0, rows[i].addr, 32'h0);
			`CHK(rd, {16'h0000, rows[i].exp})
			if (i < 8) begin
				tick(1);
				`CHK(periph_clk_en[16*i+:16], 16'h0000)
				apb(1'b1, rows[i].addr, 32'h0);
				tick(1);
				`CHK(periph_clk_en[16*i+:16], impl[i])
			end else apb(1'b1, rows[i].addr, 32'h0);
		end
		for (int v = 0; v < 4; v++) begin
			apb(1'b1, 12'h064, 32'((v >> 1) << 12 | (v & 1) << 8));
			tick(2);
			`CHK(sleep_variant, 2'(v))
		end
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h060, 32'(c << 12 | 16'h0800));
			tick(2);
			`CHK(doze_active, 1'b1)
			gap;
			gap;
			`CHK(n, per[c])
		end
		// New ratio waits out the long 1:256 period before it applies
		apb(1'b1, 12'h060, 32'h0000_3800);
		gap;
		gap;
		`CHK(n, per[3])
		irq_event <= 1'b1;
		tick(1);
		irq_event <= 1'b0;
		tick(20);
		`CHK(doze_active, 1'b1)
		apb(1'b0, 12'h060, 32'h0);
		`CHK(rd, 32'h0000_3800)
		apb(1'b1, 12'h060, 32'h0000_B800);
		tick(2);
		irq_event <= 1'b1;
		tick(1);
		irq_event <= 1'b0;
		tick(20);
		`CHK(doze_active, 1'b0)
		apb(1'b0, 12'h060, 32'h0);
		`CHK(rd, 32'h0000_B000)
		apb(1'b1, 12'h060, 32'h0);
		// Own enable, idle stop and gating of the converter
		apb(1'b1, 12'h020, 32'h1);
		cpu_idle <= 1'b1;
		tick(3);
		`CHK(periph_run[3:0], 4'h1)
		apb(1'b1, 12'h040, 32'h1);
		tick(3);
		`CHK(periph_run[0], 1'b0)
		cpu_idle <= 1'b0;
		tick(3);
		`CHK(periph_run[0], 1'b1)
		// Own enable off stops the function yet keeps the register port
		apb(1'b1, 12'h020, 32'h0);
		tick(2);
		`CHK({periph_run[0], periph_regs_en[0]}, 2'b01)
		apb(1'b1, 12'h000, 32'h1);
		tick(3);
		`CHK({periph_run[0], periph_regs_en[0]}, 2'b00)
		pstrb <= 4'h0;
		apb(1'b1, 12'h000, 32'hFFFF);
		pstrb <= 4'hF;
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b1, 12'h0FC, 32'hFFFF);
		`CHK(err, 1'b1)
		do_reset;
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h0)
		test_done;
	end
endmodule // power_save_clock_gating_bench

bind power_save_clock_gating power_save_clock_gating_properties #(.N_GATE(N_GATE)) props_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .cpu_clk_en(cpu_clk_en), .doze_active(doze_active), .sleep_variant(sleep_variant),
	.periph_clk_en(periph_clk_en), .periph_regs_en(periph_regs_en), .periph_run(periph_run));
